// ---- rtl/apo_output_port.sv ----
`timescale 1ns/10ps

// Notes on behaviour
// - Each result leaves on a 14-bit bus, bit 13 the most significant, bit 0 the least.
// - A data-ready clock goes out beside the bus as the capture reference.
// - The out-of-range flag is high exactly when the word sits at either full-scale code.
// - Four modes pick offset binary or two's complement and rising or falling capture edge.
// - Data and flag are driven only while output enable is high, else high impedance.
// - Positive overdrive gives 0x3FFF offset binary or 0x1FFF two's complement.
// - Negative overdrive gives 0x0000 offset binary or 0x2000 two's complement.
// - A reset pulse of at least 2 us clears the block and forces the data outputs low.
// - Power-down places the data and flag outputs in high impedance; the data-ready clock keeps running.
module apo_output_port (
  // System clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Sample clock domain
  input wire logic sample_clock_i,
  input wire logic [13:0] core_result_i,
  input wire logic over_pos_i,
  input wire logic over_neg_i,
  // Configuration pins
  input wire logic [1:0] format_polarity_select_i,
  input wire logic output_enable_i,
  input wire logic power_down_bit_i,
  // Output pins
  output logic [13:0] result_o,
  output logic [13:0] result_oe_o,
  output logic out_of_range_flag_o,
  output logic out_of_range_flag_oe_o,
  output logic data_ready_clock_o,
  output logic reset_done_o
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // The mode crosses into the sample domain as a Gray code, so a step to a neighbouring mode
  // flips one wire only and the far side never latches a mix of old and new bits.
  function automatic logic [1:0] mode_to_gray(input logic [1:0] bin);
    return {bin[1], bin[1] ^ bin[0]};
  endfunction : mode_to_gray

  function automatic logic [1:0] gray_to_mode(input logic [1:0] gray);
    return {gray[1], gray[1] ^ gray[0]};
  endfunction : gray_to_mode

  function automatic logic mode_is_twos(input apo_pkg::apo_mode_e m);
    return (m == apo_pkg::APO_TC_RISE) || (m == apo_pkg::APO_TC_FALL);
  endfunction : mode_is_twos

  function automatic logic mode_is_fall(input apo_pkg::apo_mode_e m);
    return (m == apo_pkg::APO_OB_FALL) || (m == apo_pkg::APO_TC_FALL);
  endfunction : mode_is_fall

  function automatic logic is_full_scale(input logic [13:0] word, input logic [13:0] hi,
    input logic [13:0] lo);
    return (word == hi) || (word == lo);
  endfunction : is_full_scale

  // ----------------------------------------------------------------
  // Reset release in the system domain
  // ----------------------------------------------------------------
  // The pin clears everything at once, but its release passes two flops and then clear_reg, so that
  // clear_reg and reset_done_o never leave reset close to a clock edge.
  logic [1:0] rst_sync_reg;
  logic clear_reg;
  logic clear_next;
  logic done_reg;
  logic done_next;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rst_sync_reg <= 2'b11;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b0};
    end
  end

  assign clear_next = rst_sync_reg[1];
  assign done_next = ~rst_sync_reg[1];

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      clear_reg <= 1'b1;
      done_reg <= 1'b0;
    end else begin
      clear_reg <= clear_next;
      done_reg <= done_next;
    end
  end

  assign reset_done_o = done_reg;

  // ----------------------------------------------------------------
  // Configuration pins into the system domain
  // ----------------------------------------------------------------
  logic [1:0] mode_s0_reg;
  logic [1:0] mode_s1_reg;
  logic [1:0] mode_gray_reg;
  logic [1:0] mode_gray_next;
  logic oe_s0_reg;
  logic oe_s1_reg;
  logic pd_s0_reg;
  logic pd_s1_reg;

  assign mode_gray_next = mode_to_gray(mode_s1_reg);

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      mode_s0_reg <= 2'h0;
      mode_s1_reg <= 2'h0;
      mode_gray_reg <= 2'h0;
      oe_s0_reg <= 1'b0;
      oe_s1_reg <= 1'b0;
      pd_s0_reg <= 1'b0;
      pd_s1_reg <= 1'b0;
    end else begin
      mode_s0_reg <= format_polarity_select_i;
      mode_s1_reg <= mode_s0_reg;
      mode_gray_reg <= mode_gray_next;
      oe_s0_reg <= output_enable_i;
      oe_s1_reg <= oe_s0_reg;
      pd_s0_reg <= power_down_bit_i;
      pd_s1_reg <= pd_s0_reg;
    end
  end

  // ----------------------------------------------------------------
  // Level crossings into the sample domain
  // ----------------------------------------------------------------
  logic [1:0] mode_l0_reg;
  logic [1:0] mode_l1_reg;
  logic clr_l0_reg;
  logic clr_l1_reg;

  always_ff @(posedge sample_clock_i or posedge rst_i) begin
    if (rst_i) begin
      mode_l0_reg <= 2'h0;
      mode_l1_reg <= 2'h0;
      clr_l0_reg <= 1'b1;
      clr_l1_reg <= 1'b1;
    end else begin
      mode_l0_reg <= mode_gray_reg;
      mode_l1_reg <= mode_l0_reg;
      clr_l0_reg <= clear_reg;
      clr_l1_reg <= clr_l0_reg;
    end
  end

  // ----------------------------------------------------------------
  // Coding and overdrive in the sample domain
  // ----------------------------------------------------------------
  apo_pkg::apo_mode_e mode;
  logic twos;
  logic fall_edge;
  logic [13:0] pos_code;
  logic [13:0] neg_code;
  logic [13:0] coded;
  logic [13:0] word_next;
  apo_pkg::apo_sample_s samp_next;
  apo_pkg::apo_sample_s samp_reg;

  assign mode = apo_pkg::apo_mode_e'(gray_to_mode(mode_l1_reg));
  assign twos = mode_is_twos(mode);
  assign fall_edge = mode_is_fall(mode);
  assign pos_code = twos ? apo_pkg::TC_POS_FULL : apo_pkg::OB_POS_FULL;
  assign neg_code = twos ? apo_pkg::TC_NEG_FULL : apo_pkg::OB_NEG_FULL;
  assign coded = twos ? (core_result_i ^ apo_pkg::SIGN_FLIP) : core_result_i;
  // Positive overdrive wins if the core ever flags both at once.
  assign word_next = over_pos_i ? pos_code : (over_neg_i ? neg_code : coded);
  assign samp_next.word = word_next;
  assign samp_next.out_of_range = is_full_scale(word_next, pos_code, neg_code);

  always_ff @(posedge sample_clock_i or posedge rst_i) begin
    if (rst_i) begin
      samp_reg <= '0;
    end else if (clr_l1_reg) begin
      samp_reg <= '0;
    end else begin
      samp_reg <= samp_next;
    end
  end

  // ----------------------------------------------------------------
  // Data-ready clock and data pins
  // ----------------------------------------------------------------
  // The data-ready clock is the sample clock, inverted in the rising-edge modes; the select picks which edge is the capture
  // edge. Words change on the rising sample edge, so the capture edge sits mid-period.
  assign data_ready_clock_o = fall_edge ? sample_clock_i : ~sample_clock_i;
  assign result_o = samp_reg.word;
  assign out_of_range_flag_o = samp_reg.out_of_range;

  // ----------------------------------------------------------------
  // Output enables
  // ----------------------------------------------------------------
  logic drive;

  assign drive = oe_s1_reg && !pd_s1_reg;
  assign result_oe_o = {apo_pkg::RESULT_W{drive}};
  assign out_of_range_flag_oe_o = drive;

endmodule : apo_output_port

// ---- rtl/apo_pkg.sv ----
package apo_pkg;

  // ----------------------------------------------------------------
  // Word layout and fixed codes
  // ----------------------------------------------------------------
  localparam int unsigned RESULT_W = 14;
  localparam logic [13:0] OB_POS_FULL = 14'h3fff;
  localparam logic [13:0] OB_NEG_FULL = 14'h0000;
  localparam logic [13:0] TC_POS_FULL = 14'h1fff;
  localparam logic [13:0] TC_NEG_FULL = 14'h2000;
  localparam logic [13:0] SIGN_FLIP = 14'h2000;
  localparam logic [13:0] WORD_RESET = 14'h0000;

  // ----------------------------------------------------------------
  // Reset timing
  // ----------------------------------------------------------------
  localparam int unsigned RESET_MIN_NS = 2000;
  localparam int unsigned SYS_PERIOD_NS = 5;
  localparam int unsigned RESET_MIN_CYC = (RESET_MIN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

  // ----------------------------------------------------------------
  // Modes of the four-level select input
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    APO_OB_RISE,
    APO_OB_FALL,
    APO_TC_RISE,
    APO_TC_FALL
  } apo_mode_e;

  typedef struct packed {
    logic [13:0] word;
    logic out_of_range;
  } apo_sample_s;

endpackage : apo_pkg

// ---- tb/apo_output_port_properties.sv ----
`timescale 1ns/10ps
module apo_output_port_chk (
  input wire logic sample_clock_i, rst_i, output_enable_i, power_down_bit_i,
  input wire logic over_pos_i, over_neg_i, out_of_range_flag_o, out_of_range_flag_oe_o,
  input wire logic data_ready_clock_o,
  input wire logic [1:0] format_polarity_select_i,
  input wire logic [13:0] core_result_i, result_o, result_oe_o
);
  default clocking @(posedge sample_clock_i); endclocking
  default disable iff (rst_i);
  wire [13:0] flip = format_polarity_select_i[1] ? apo_pkg::SIGN_FLIP : 14'h0000;
  wire [13:0] ob = result_o ^ flip;
  // Reset release and mode changes settle over a few sample edges, so checks wait for calm.
  logic [2:0] since_rst;
  always_ff @(posedge sample_clock_i or posedge rst_i) begin
    if (rst_i) begin
      since_rst <= 3'd0;
    end else if (since_rst != 3'd7) begin
      since_rst <= since_rst + 3'd1;
    end
  end
  sequence s_calm; ($stable(format_polarity_select_i) && since_rst == 3'd7) [*3]; endsequence
  property p_pos; s_calm ##0 over_pos_i |=> (result_o ^ $past(flip)) == 14'h3fff; endproperty
  a_pos: assert property (p_pos) else $error("positive overdrive code wrong");
  property p_neg; s_calm ##0 over_neg_i && !over_pos_i |=> (result_o ^ $past(flip)) == 14'h0000;
  endproperty
  a_neg: assert property (p_neg) else $error("negative overdrive code wrong");
  property p_word; s_calm ##0 !over_pos_i && !over_neg_i |=>
    (result_o ^ $past(flip)) == $past(core_result_i); endproperty
  a_word: assert property (p_word) else $error("result word wrong");
  property p_flag; s_calm |-> out_of_range_flag_o == (ob == 14'h3fff || ob == 14'h0000);
  endproperty
  a_flag: assert property (p_flag) else $error("range flag wrong");
  property p_rst; disable iff (1'b0) rst_i |-> result_o == apo_pkg::WORD_RESET; endproperty
  a_rst: assert property (p_rst) else $error("word not cleared in reset");
  property p_off; !output_enable_i [*2] |-> result_oe_o == 14'h0000 && !out_of_range_flag_oe_o;
  endproperty
  a_off: assert property (p_off) else $error("outputs driven while disabled");
  property p_on; (output_enable_i && !power_down_bit_i) [*2] |->
    result_oe_o == 14'h3fff && out_of_range_flag_oe_o; endproperty
  a_on: assert property (p_on) else $error("outputs not driven");
  property p_pdn; power_down_bit_i [*2] |-> result_oe_o == 14'h0000 && !out_of_range_flag_oe_o;
  endproperty
  a_pdn: assert property (p_pdn) else $error("outputs driven in power-down");
  property p_drc; s_calm |-> data_ready_clock_o == !format_polarity_select_i[0]; endproperty
  a_drc: assert property (p_drc) else $error("data-ready clock phase wrong");
endmodule : apo_output_port_chk
bind apo_output_port apo_output_port_chk u_chk (.sample_clock_i, .rst_i, .output_enable_i,
  .power_down_bit_i, .over_pos_i, .over_neg_i, .out_of_range_flag_o, .out_of_range_flag_oe_o,
  .data_ready_clock_o, .format_polarity_select_i, .core_result_i, .result_o, .result_oe_o);

// ---- tb/apo_capture.sv ----
`timescale 1ns/10ps
module apo_capture (
  input wire logic drc_i, fall_i,
  input wire logic [14:0] pin_i,
  output logic [14:0] cap_o,
  output logic got_o
);
  initial got_o = 1'b0;
  // Capture on the mid-period edge, where the word has long settled.
  always @(drc_i) if (drc_i ^ fall_i) begin
    cap_o <= pin_i;
    got_o <= ~got_o;
  end
endmodule : apo_capture

// ---- tb/apo_output_port_tb_top.sv ----
`timescale 1ns/10ps
module apo_output_port_tb_top;
  logic clk_sys_i = 1'b0, rst_i = 1'b0, sample_clock_i = 1'b0, over_pos_i = 1'b0, got;
  logic reset_done_o;
  logic over_neg_i = 1'b0, output_enable_i = 1'b1, power_down_bit_i = 1'b0;
  logic [1:0] format_polarity_select_i = 2'h0;
  logic [13:0] core_result_i = 14'h0000, result_o, result_oe_o;
  logic out_of_range_flag_o, out_of_range_flag_oe_o, data_ready_clock_o;
  logic [14:0] cap;
  logic [15:0] lf = 16'h0017;
  int error_cnt = 0, samples_checked = 0;
  apo_pkg::apo_sample_s q[$];
  wire [14:0] pins = {result_oe_o[0] ? result_o : 14'hzzzz,
    out_of_range_flag_oe_o ? out_of_range_flag_o : 1'bz};
  apo_output_port u_apo_output_port (.clk_sys_i, .rst_i, .sample_clock_i, .core_result_i,
    .over_pos_i, .over_neg_i, .format_polarity_select_i, .output_enable_i, .power_down_bit_i,
    .result_o, .result_oe_o, .out_of_range_flag_o, .out_of_range_flag_oe_o,
    .data_ready_clock_o, .reset_done_o);
  apo_capture u_apo_capture (.drc_i(data_ready_clock_o), .fall_i(format_polarity_select_i[0]),
    .pin_i(pins), .cap_o(cap), .got_o(got));
  always #2.5 clk_sys_i = ~clk_sys_i;
  initial #13 forever #40 sample_clock_i = ~sample_clock_i;
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nx
  task automatic cmp(input string n, input logic [14:0] e, input logic [14:0] g);
    samples_checked++;
    if (e !== g) begin
      error_cnt++;
      $display("Error %s exp %h got %h", n, e, g);
    end
  endtask : cmp
  task automatic stop_test();
    if (error_cnt == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  always @(got) if (q.size() > 0) cmp("sample", q.pop_front(), cap);
  task automatic burst();
    logic [13:0] ob;
    for (int i = 0; i < 12; i++) begin
      @(negedge sample_clock_i);
      lf = nx(lf);
      core_result_i = (i == 7) ? 14'h0000 : (i == 9) ? 14'h3fff : lf[13:0];
      over_pos_i = (i == 3);
      over_neg_i = (i == 3) || (i == 5);
      ob = over_pos_i ? 14'h3fff : over_neg_i ? 14'h0000 : core_result_i;
      @(posedge sample_clock_i);
      q.push_back({ob ^ (format_polarity_select_i[1] ? apo_pkg::SIGN_FLIP : 14'h0000),
        ob == 14'h3fff || ob == 14'h0000});
    end
    for (int k = 0; k < 40 && q.size() > 0; k++) @(posedge clk_sys_i);
    if (q.size() > 0) begin
      error_cnt++;
      stop_test();
    end
  endtask : burst
  task automatic quiet(input logic oe, input logic pd);
    @(negedge clk_sys_i);
    output_enable_i = oe;
    power_down_bit_i = pd;
    repeat (3) @(posedge sample_clock_i);
    cmp("enable", 15'h0000, {result_oe_o, out_of_range_flag_oe_o});
    @(negedge clk_sys_i);
    output_enable_i = 1'b1;
    power_down_bit_i = 1'b0;
  endtask : quiet
  initial begin
    #1 rst_i = 1'b1;
    repeat (16) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    rst_i = 1'b0;
    for (int m = 0; m < 4; m++) begin
      @(negedge clk_sys_i);
      format_polarity_select_i = m[1:0];
      repeat (4) @(posedge sample_clock_i);
      burst();
    end
    quiet(1'b0, 1'b0);
    quiet(1'b1, 1'b1);
    @(negedge clk_sys_i);
    rst_i = 1'b1;
    repeat (20) @(posedge clk_sys_i);
    cmp("reset", 15'h0000, {result_o, out_of_range_flag_o});
    cmp("reset done", 15'h0000, {14'h0000, reset_done_o});
    @(negedge clk_sys_i);
    rst_i = 1'b0;
    repeat (4) @(posedge sample_clock_i);
    cmp("reset done", 15'h0001, {14'h0000, reset_done_o});
    burst();
    stop_test();
  end
endmodule : apo_output_port_tb_top
